// [verilog/cpu_bus_wait_and_irq_entry.sv]
// bus control, wait halt and maskable interrupt entry
`timescale 1ns/100ps
module cpu_bus_wait_and_irq_entry
    import cpu_bus_pkg::*;
(
    input  wire logic        clock,              // 125 mhz clock
    input  wire logic        resetn,             // sync reset, low
    input  wire logic        data_output_enable, // external driver enable
    input  wire logic        wait_n,             // wait input, low halts
    input  wire logic        irq_n,              // maskable request, low
    input  wire logic        insn_done,          // core: last insn cycle
    input  wire logic        core_write,         // core: cycle is a write
    input  wire logic [15:0] core_addr,          // core: address to drive
    input  wire logic [15:0] core_pc,            // core: program counter
    input  wire logic [7:0]  core_wdata,         // core: write data
    input  wire logic        mask_clear,         // core: software clears mask
    input  wire logic [7:0]  data_bus_in,        // data bus pin level
    output logic      [7:0]  data_bus_out,       // data bus drive value
    output logic             data_bus_oe,        // data bus drive enable
    output logic      [15:0] address_bus,        // address bus
    output logic             write_cycle,        // current cycle writes
    output logic             bus_released,       // buses free for dma
    output logic             phase_one_clock,    // phase one
    output logic             phase_two_clock,    // phase two
    output logic             core_advance,       // core may step cycle
    output logic             pc_load,            // vector load pulse
    output logic      [15:0] pc_vector,          // vector loaded value
    output logic      [7:0]  status_q_out        // status register
);
    import cpu_bus_pkg::*;

    logic doe_s, wait_s, irq_s;

    ////////////////////////////////////////////////////////////////
    // pin synchronisers
    pin_sync u_doe (.clock(clock), .resetn(resetn),
                    .pin(data_output_enable), .level(doe_s));
    pin_sync u_wait (.clock(clock), .resetn(resetn),
                     .pin(wait_n), .level(wait_s));
    pin_sync u_irq (.clock(clock), .resetn(resetn),
                    .pin(irq_n), .level(irq_s));

    ////////////////////////////////////////////////////////////////
    // phase generator: non-overlapping phases with a dead clock
    logic [1:0] div_q, div_d;
    logic       ph2_q, ph2_d;
    logic       ph2_end;
    always_comb begin
        div_d   = div_q + 2'h1;
        ph2_end = (div_q == PHASE_LAST) && ph2_q;
        ph2_d   = (div_q == PHASE_LAST) ? !ph2_q : ph2_q;
    end
    always_ff @(posedge clock) begin
        if (!resetn) begin
            div_q <= 2'h0;
            ph2_q <= 1'b0;
        end else begin
            div_q <= div_d;
            ph2_q <= ph2_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // wait halt, bus release, interrupt sequencing
    seq_type     seq_q, seq_d;
    logic        halt_q, halt_d;
    logic        pend_q, pend_d;
    logic [7:0]  sp_q, sp_d;
    logic [7:0]  st_q, st_d;
    logic [7:0]  vlo_q, vlo_d;
    logic        wr_d, adv_d, pcl_d, ba_d, p1_d, p2_d, oe_d;
    logic [15:0] addr_d, vec_d, pcl_vec_q;
    logic [7:0]  dout_d;
    logic        wr_q, adv_q, pcl_q, ba_q, p1_q, p2_q, oe_q;
    logic [15:0] addr_q;
    logic [7:0]  dout_q;
    logic        seq_wr;

    always_comb begin
        seq_d  = seq_q;
        halt_d = halt_q;
        pend_d = pend_q;
        sp_d   = sp_q;
        st_d   = st_q;
        vlo_d  = vlo_q;
        adv_d  = 1'b0;
        pcl_d  = 1'b0;
        vec_d  = pcl_vec_q;
        seq_wr = (seq_q == ST_PUSH_HI) || (seq_q == ST_PUSH_LO)
              || (seq_q == ST_PUSH_ST);
        wr_d   = (seq_q == ST_RUN) ? core_write : seq_wr;
        if (mask_clear)
            st_d[MASK_BIT] = 1'b0;
        // halt when wait low in phase one of non-write cycle
        if (!ph2_q && !wait_s && !wr_q)
            halt_d = 1'b1;
        // release only after a phase two with wait high
        if (ph2_end && wait_s)
            halt_d = 1'b0;
        // sample request in phase two, only with wait high
        if (ph2_end && wait_s)
            pend_d = !irq_s;
        // write cycles complete even with wait low
        if (ph2_end && !halt_q && (wait_s || wr_q)) begin
            case (seq_q)
            ST_RUN: begin
                adv_d = 1'b1;
                if (insn_done && pend_q && wait_s
                    && !st_q[MASK_BIT])
                    seq_d = ST_PUSH_HI;
            end
            ST_PUSH_HI: begin
                sp_d  = sp_q - 8'h01;
                seq_d = ST_PUSH_LO;
            end
            ST_PUSH_LO: begin
                sp_d  = sp_q - 8'h01;
                seq_d = ST_PUSH_ST;
            end
            ST_PUSH_ST: begin
                sp_d  = sp_q - 8'h01;
                st_d[MASK_BIT] = 1'b1;
                seq_d = ST_VEC_LO;
            end
            ST_VEC_LO: begin
                vlo_d = data_bus_in;
                seq_d = ST_VEC_HI;
            end
            ST_VEC_HI: begin
                pcl_d = 1'b1;
                vec_d = {data_bus_in, vlo_q};
                seq_d = ST_RUN;
            end
            default: seq_d = ST_RUN;
            endcase
        end
        case (seq_q)
        ST_PUSH_HI: addr_d = STACK_PAGE | {8'h00, sp_q};
        ST_PUSH_LO: addr_d = STACK_PAGE | {8'h00, sp_q};
        ST_PUSH_ST: addr_d = STACK_PAGE | {8'h00, sp_q};
        ST_VEC_LO:  addr_d = VEC_LOW_ADDR;
        ST_VEC_HI:  addr_d = VEC_HIGH_ADDR;
        default:    addr_d = core_addr;
        endcase
        // hold current fetch address while halted
        if (halt_q)
            addr_d = addr_q;
        case (seq_q)
        ST_PUSH_HI: dout_d = core_pc[15:8];
        ST_PUSH_LO: dout_d = core_pc[7:0];
        ST_PUSH_ST: dout_d = st_q;
        default:    dout_d = core_wdata;
        endcase
        // drive only on writes with external enable high
        oe_d = wr_q && doe_s;
        // released when wait low and not writing
        ba_d = !wait_s && !wr_q;
        p1_d = !ph2_q && (div_q != PHASE_LAST);
        p2_d = ph2_q && (div_q != PHASE_LAST);
        if (halt_q)
            wr_d = wr_q;
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            seq_q     <= ST_RUN;
            halt_q    <= 1'b0;
            pend_q    <= 1'b0;
            sp_q      <= SP_RESET;
            st_q      <= STATUS_RESET;
            vlo_q     <= 8'h00;
            pcl_vec_q <= PC_RESET;
            wr_q      <= 1'b0;
            adv_q     <= 1'b0;
            pcl_q     <= 1'b0;
            ba_q      <= 1'b0;
            p1_q      <= 1'b0;
            p2_q      <= 1'b0;
            oe_q      <= 1'b0;
            addr_q    <= PC_RESET;
            dout_q    <= 8'h00;
        end else begin
            seq_q     <= seq_d;
            halt_q    <= halt_d;
            pend_q    <= pend_d;
            sp_q      <= sp_d;
            st_q      <= st_d;
            vlo_q     <= vlo_d;
            pcl_vec_q <= vec_d;
            wr_q      <= wr_d;
            adv_q     <= adv_d;
            pcl_q     <= pcl_d;
            ba_q      <= ba_d;
            p1_q      <= p1_d;
            p2_q      <= p2_d;
            oe_q      <= oe_d;
            addr_q    <= addr_d;
            dout_q    <= dout_d;
        end
    end

    assign data_bus_out    = dout_q;
    assign data_bus_oe     = oe_q;
    assign address_bus     = addr_q;
    assign write_cycle     = wr_q;
    assign bus_released    = ba_q;
    assign phase_one_clock = p1_q;
    assign phase_two_clock = p2_q;
    assign core_advance    = adv_q;
    assign pc_load         = pcl_q;
    assign pc_vector       = pcl_vec_q;
    assign status_q_out    = st_q;

    ////////////////////////////////////////////////////////////////
    // assertions
    read_no_drive_a: assert property (@(posedge clock) disable iff (!resetn)
        !wr_q |=> !oe_q) else $error("driver on in read");
    oe_follows_a: assert property (@(posedge clock) disable iff (!resetn)
        oe_q |-> $past(doe_s)) else $error("driver without enable");
    release_eq_a: assert property (@(posedge clock) disable iff (!resetn)
        ##1 ba_q == $past(!wait_s && !wr_q))
        else $error("bus released mismatch");
    halt_hold_a: assert property (@(posedge clock) disable iff (!resetn)
        halt_q && $past(halt_q) |-> $stable(addr_q))
        else $error("address moved while halted");
    no_adv_halt_a: assert property (@(posedge clock) disable iff (!resetn)
        halt_q |=> !adv_q) else $error("advance while halted");
    mask_set_a: assert property (@(posedge clock) disable iff (!resetn)
        seq_q == ST_PUSH_ST && seq_d == ST_VEC_LO |=> st_q[MASK_BIT])
        else $error("mask not set");
    masked_idle_a: assert property (@(posedge clock) disable iff (!resetn)
        seq_q == ST_RUN && st_q[MASK_BIT] |=> seq_q == ST_RUN)
        else $error("entry while masked");
    vec_addr_a: assert property (@(posedge clock) disable iff (!resetn)
        seq_q == ST_VEC_HI && !halt_q |=> addr_q == VEC_HIGH_ADDR)
        else $error("wrong vector address");
    no_overlap_a: assert property (@(posedge clock) disable iff (!resetn)
        !(p1_q && p2_q)) else $error("phases overlap");
    entry_cov: cover property (@(posedge clock) disable iff (!resetn)
        pcl_q);
    halt_cov: cover property (@(posedge clock) disable iff (!resetn)
        $rose(halt_q));
    release_cov: cover property (@(posedge clock) disable iff (!resetn)
        $rose(ba_q));
endmodule // cpu_bus_wait_and_irq_entry

// [verilog/cpu_bus_pkg.sv]
// constants for the processor bus wait and interrupt entry block
package cpu_bus_pkg;
    localparam logic [15:0] VEC_LOW_ADDR  = 16'hff9f;
    localparam logic [15:0] VEC_HIGH_ADDR = 16'hff7f;
    localparam logic [15:0] STACK_PAGE    = 16'h0100;
    localparam logic [7:0]  SP_RESET      = 8'hff;
    localparam logic [7:0]  STATUS_RESET  = 8'h04;
    localparam int          MASK_BIT      = 2;
    localparam logic [15:0] PC_RESET      = 16'h0000;
    // phase counter: 4 clocks per bus phase, two phases per cycle
    localparam logic [1:0]  PHASE_LAST    = 2'h3;
    typedef enum logic [2:0] {
        ST_RUN, ST_PUSH_HI, ST_PUSH_LO, ST_PUSH_ST, ST_VEC_LO, ST_VEC_HI
    } seq_type;
endpackage

// [verilog/pin_sync.sv]
// three-stage pin synchroniser with agreement check
`timescale 1ns/100ps
module pin_sync (
    input  wire logic clock,   // system clock
    input  wire logic resetn,  // synchronous reset, low active
    input  wire logic pin,     // asynchronous pin
    output logic      level    // filtered level
);
    logic s1_q, s2_q, s3_q, lvl_q;
    logic s1_d, s2_d, s3_d, lvl_d;
    // shift in and accept change when stages two and three agree
    always_comb begin
        s1_d  = pin;
        s2_d  = s1_q;
        s3_d  = s2_q;
        lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
    end
    always_ff @(posedge clock) begin
        if (!resetn) begin
            s1_q  <= 1'b1;
            s2_q  <= 1'b1;
            s3_q  <= 1'b1;
            lvl_q <= 1'b1;
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            s3_q  <= s3_d;
            lvl_q <= lvl_d;
        end
    end
    assign level = lvl_q;
endmodule // pin_sync

// [testbench/bus_memory_model.sv]
// memory and peripheral model on the far side of the processor buses
`timescale 1ns/100ps
module bus_memory_model (
    input  wire logic        clock,        // system clock
    input  wire logic [15:0] address_bus,  // address from device
    input  wire logic [7:0]  data_bus_out, // device drive value
    input  wire logic        data_bus_oe,  // device drive enable
    input  wire logic        write_cycle,  // device cycle writes
    output logic      [7:0]  data_bus_in   // resolved data bus level
);
    logic [7:0] mem [0:65535];
    logic [7:0] float_q;
    // known fill, then the two vector bytes
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = i[7:0];
        mem[16'hff9f] = 8'h34;
        mem[16'hff7f] = 8'h12;
        float_q = 8'h00;
    end
    // capture writes; floating pattern changes every cycle
    always @(posedge clock) begin
        if (write_cycle && data_bus_oe) begin
            mem[address_bus] <= data_bus_out;
        end
        float_q <= ~float_q;
    end
    // memory answers reads; an undriven bus never holds its last value
    always_comb begin
        if (data_bus_oe) data_bus_in = data_bus_out;
        else if (!write_cycle) data_bus_in = mem[address_bus];
        else data_bus_in = float_q;
    end
endmodule // bus_memory_model

// [testbench/cpu_bus_wait_and_irq_entry_bench.sv]
// self-checking bench for wait halt, data bus and interrupt entry
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module cpu_bus_wait_and_irq_entry_bench;
    import cpu_bus_pkg::*;
    logic clock = 0, resetn = 0, wait_n = 1, irq_n = 1, insn_done = 0;
    logic core_write = 0, mask_clear = 0, data_output_enable = 0;
    logic [15:0] core_addr = 16'h2345;
    logic [1:0] doe_mode = 0;
    logic [7:0] data_bus_in, data_bus_out, status_q_out;
    logic [15:0] address_bus, pc_vector;
    logic data_bus_oe, write_cycle, bus_released, p1, p2, adv, pc_load;
    int n_fail = 0, n_tests = 0, n_adv, n_rel, n_oe, n_pl, n_chg, n_ovl;
    always #4 clock = ~clock;
    // enable: off, on, or following phase two
    always @(posedge clock) begin
        data_output_enable <= doe_mode[1] ? p2 : doe_mode[0];
    end
    cpu_bus_wait_and_irq_entry dut_u (.clock(clock), .resetn(resetn),
        .data_output_enable(data_output_enable), .wait_n(wait_n),
        .irq_n(irq_n), .insn_done(insn_done), .core_write(core_write),
        .core_addr(core_addr), .core_pc(16'hbeef), .core_wdata(8'ha5),
        .mask_clear(mask_clear), .data_bus_in(data_bus_in),
        .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
        .address_bus(address_bus), .write_cycle(write_cycle),
        .bus_released(bus_released), .phase_one_clock(p1),
        .phase_two_clock(p2), .core_advance(adv), .pc_load(pc_load),
        .pc_vector(pc_vector), .status_q_out(status_q_out));
    bus_memory_model mem_u (.clock(clock), .address_bus(address_bus),
        .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
        .write_cycle(write_cycle), .data_bus_in(data_bus_in));
    ////////////////////////////////////////////////////////////////////
    // count output activity over n settled samples
    task automatic watch(input int n);
        logic [15:0] a0;
        a0 = address_bus;
        {n_adv, n_rel, n_oe, n_pl, n_chg, n_ovl} = '0;
        repeat (n) begin
            @(negedge clock);
            n_adv += (adv === 1'b1);
            n_rel += (bus_released === 1'b1);
            n_oe += (data_bus_oe === 1'b1);
            n_pl += (pc_load === 1'b1);
            n_chg += (address_bus !== a0);
            n_ovl += (p1 === 1'b1 && p2 === 1'b1);
        end
    endtask
    task automatic tally_and_finish;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // values right after reset
    task automatic t_reset;
        `CHK(address_bus, PC_RESET)
        `CHK(status_q_out, STATUS_RESET)
        `CHK(bus_released, 1'b0)
        `CHK(data_bus_oe, 1'b0)
    endtask
    // read cycle halted by wait low, then resumed
    task automatic t_halt;
        @(posedge clock) wait_n <= 1'b0;
        watch(16);
        // a new core address must not reach the pins while halted
        @(posedge clock) core_addr <= 16'h3456;
        watch(32);
        `CHK(n_rel, 32)
        `CHK(n_adv, 0)
        `CHK(n_chg, 0)
        `CHK(n_ovl, 0)
        @(posedge clock) wait_n <= 1'b1;
        watch(32);
        `CHK(n_adv > 0, 1'b1)
        `CHK(bus_released, 1'b0)
        `CHK(address_bus, 16'h3456)
    endtask
    // write cycles ignore wait, drive only with enable, defer to read
    task automatic t_write;
        @(posedge clock) begin
            core_write <= 1'b1;
            core_addr <= 16'h2345;
            wait_n <= 1'b0;
            doe_mode <= 2'h2;
        end
        watch(40);
        `CHK(n_rel, 0)
        `CHK(n_adv > 0, 1'b1)
        `CHK(n_oe > 0 && n_oe < 40, 1'b1)
        `CHK(mem_u.mem[16'h2345], 8'ha5)
        @(posedge clock) doe_mode <= 2'h0;
        watch(16);
        watch(32);
        `CHK(n_oe, 0)
        @(posedge clock) begin
            core_write <= 1'b0;
            doe_mode <= 2'h1;
        end
        watch(16);
        watch(32);
        `CHK(n_oe, 0)
        `CHK(n_rel, 32)
        @(posedge clock) begin
            wait_n <= 1'b1;
            doe_mode <= 2'h2;
        end
    endtask
    // refusals, then one full entry with push and vector
    task automatic t_irq;
        @(posedge clock) begin
            irq_n <= 1'b0;
            insn_done <= 1'b1;
        end
        watch(64);
        `CHK(n_pl, 0)
        @(posedge clock) begin
            insn_done <= 1'b0;
            mask_clear <= 1'b1;
        end
        @(posedge clock) mask_clear <= 1'b0;
        watch(64);
        `CHK(n_pl, 0)
        // wait settles low before the instruction ends
        @(posedge clock) wait_n <= 1'b0;
        watch(16);
        @(posedge clock) insn_done <= 1'b1;
        watch(64);
        `CHK(n_pl, 0)
        @(posedge clock) wait_n <= 1'b1;
        watch(120);
        `CHK(n_pl, 1)
        `CHK(mem_u.mem[16'h01ff], 8'hbe)
        `CHK(mem_u.mem[16'h01fe], 8'hef)
        `CHK(mem_u.mem[16'h01fd], 8'h00)
        `CHK(pc_vector, 16'h1234)
        `CHK(status_q_out[MASK_BIT], 1'b1)
        watch(120);
        `CHK(n_pl, 0)
        @(posedge clock) irq_n <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        @(negedge clock);
        t_reset();
        t_halt();
        t_write();
        t_irq();
        tally_and_finish();
    end
    initial begin
        repeat (3000) @(posedge clock);
        n_fail++;
        tally_and_finish();
    end
endmodule // cpu_bus_wait_and_irq_entry_bench
